// file: core/dsc_destuff_crc.sv
// Receive destuffer, checksum unit and received-bit FIFO
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Small FIFO with valid/ready on both sides
module dsc_fifo #(
   parameter int unsigned WIDTH = 1,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      fill_r;
   logic             push;
   logic             pop;

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
         $error("dsc_fifo: DEPTH must be a power of two >= 2");
      end
   end

   // Full compare at the fill counter's own width, so DEPTH never wraps to zero
   assign o_in_ready  = (fill_r != (AW+1)'(DEPTH));
   assign o_out_valid = (fill_r != '0);
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   assign o_out_data  = mem[rd_ptr_r];

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         fill_r   <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            fill_r <= fill_r + 1'b1;
         end else if (pop && !push) begin
            fill_r <= fill_r - 1'b1;
         end
      end
   end
endmodule

// ==========================================================
module dsc_destuff_crc #(
   parameter int unsigned FIFO_DEPTH = 4
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Destuffer
   input  wire logic        i_destuff_trig,
   input  wire logic        i_rx_bit,
   input  wire logic        i_destuff_en,
   input  wire logic        i_fixed_mode,
   input  wire logic        i_sof_window,
   input  wire logic        i_process_trig,
   output logic             o_rx_bit,
   output logic             o_destuffed,
   output logic             o_stuff_err,
   output logic [dsc_pkg::DSC_CNT_W-1:0] o_stuff_cnt,
   output logic             o_pc_rx_trig,
   // Received-bit stream
   output logic             o_bit_valid,
   input  wire logic        i_bit_ready,
   output logic             o_bit_data,
   output logic             o_rx_ready,
   // Checksum
   input  wire logic        i_crc_en,
   input  wire logic        i_crc_spec_en,
   input  wire logic        i_is_tx,
   input  wire logic        i_arb_done,
   input  wire logic        i_tx_nbs_trig,
   input  wire logic        i_tx_nbs_bit,
   input  wire logic        i_tx_wbs_trig,
   input  wire logic        i_tx_wbs_bit,
   output logic [14:0]      o_crc15,
   output logic [16:0]      o_crc17,
   output logic [20:0]      o_crc21
);
   import dsc_pkg::*;

   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("dsc_destuff_crc: FIFO_DEPTH must be at least 2");
      end
   end

   // ==========================================================
   // Checksum step, shared by all three widths
   function automatic logic [20:0] crc_step(input logic [20:0] crc,
                                            input logic        din,
                                            input logic [20:0] poly,
                                            input int unsigned width);
      logic        fb;
      logic [20:0] mask;
      logic [20:0] sh;
      fb   = din ^ crc[width-1];
      mask = 21'((64'h1 << width) - 64'h1);
      sh   = (crc << 1) & mask;
      return fb ? (sh ^ poly) : sh;
   endfunction

   // ==========================================================
   // Destuffer
   dsc_mode_t               mode;
   logic [DSC_CNT_W-1:0]    run_cnt_r;
   logic                    prev_r;
   logic                    fixed_prev_r;
   logic                    rx_bit_r;
   logic                    destuffed_r;
   logic                    stuff_err_r;
   logic [DSC_CNT_W-1:0]    stuff_cnt_r;
   logic                    halt_r;
   logic                    raw_bit_r;
   logic                    discard;
   logic                    first_fixed;

   always_comb begin
      mode = DSC_OFF;
      if (i_destuff_en) begin
         mode = i_fixed_mode ? DSC_FIXED : DSC_REGULAR;
      end
   end

   assign first_fixed = i_fixed_mode && !fixed_prev_r;

   always_comb begin
      case (mode)
         DSC_REGULAR: discard = (run_cnt_r == DSC_REG_LEN);
         DSC_FIXED:   discard = first_fixed || (run_cnt_r == DSC_FIX_LEN);
         default:     discard = 1'b0;
      endcase
   end

   // Equal-run counter and previous bit
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         run_cnt_r    <= DSC_RUN_START;
         prev_r       <= DSC_RECESSIVE;
         fixed_prev_r <= 1'b0;
      end else if (i_destuff_trig) begin
         fixed_prev_r <= (mode == DSC_FIXED);
         prev_r       <= i_rx_bit;
         case (mode)
            DSC_REGULAR: begin
               if (discard) begin
                  run_cnt_r <= DSC_RUN_START;
               end else if (i_rx_bit == prev_r) begin
                  run_cnt_r <= run_cnt_r + 1'b1;
               end else begin
                  run_cnt_r <= DSC_RUN_START;
               end
            end
            DSC_FIXED: begin
               // Fixed run counts processed bits after each stuff bit
               run_cnt_r <= discard ? DSC_RUN_ZERO : run_cnt_r + 1'b1;
            end
            default: begin
               run_cnt_r <= DSC_RUN_START;
               // Dominant at frame start is the first bit of the run
               prev_r    <= (i_sof_window && i_rx_bit == DSC_DOMINANT) ?
                            DSC_DOMINANT : DSC_RECESSIVE;
            end
         endcase
      end
   end

   // Registered destuffer outputs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_bit_r    <= DSC_RECESSIVE;
         destuffed_r <= 1'b0;
         stuff_err_r <= 1'b0;
         raw_bit_r   <= DSC_RECESSIVE;
      end else begin
         stuff_err_r <= 1'b0;
         if (i_destuff_trig) begin
            rx_bit_r    <= i_rx_bit;
            raw_bit_r   <= i_rx_bit;
            destuffed_r <= discard;
            stuff_err_r <= discard && (i_rx_bit == prev_r);
         end
      end
   end

   // Stuff bit count, modulo by width
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stuff_cnt_r <= '0;
      end else if (i_destuff_trig) begin
         if (mode == DSC_OFF && i_sof_window) begin
            stuff_cnt_r <= '0;
         end else if (mode == DSC_REGULAR && discard) begin
            stuff_cnt_r <= stuff_cnt_r + DSC_STUFF_ONE;
         end
      end
   end

   // Halt until the matching process trigger has been swallowed
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         halt_r <= 1'b0;
      end else if (i_destuff_trig) begin
         halt_r <= discard;
      end else if (i_process_trig) begin
         halt_r <= 1'b0;
      end
   end

   assign o_pc_rx_trig = i_process_trig && !halt_r;
   assign o_rx_bit     = rx_bit_r;
   assign o_destuffed  = destuffed_r;
   assign o_stuff_err  = stuff_err_r;
   assign o_stuff_cnt  = stuff_cnt_r;

   // ==========================================================
   // Received data bits to the FIFO, stuff bits left out
   logic push_valid;
   logic push_pend_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         push_pend_r <= 1'b0;
      end else begin
         push_pend_r <= i_destuff_trig && !discard;
      end
   end

   // A full FIFO drops the bit; o_rx_ready low is the only warning to the source
   assign push_valid = push_pend_r;

   dsc_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_rst       (i_rst),
      .i_in_valid  (push_valid),
      .o_in_ready  (o_rx_ready),
      .i_in_data   (rx_bit_r),
      .o_out_valid (o_bit_valid),
      .i_out_ready (i_bit_ready),
      .o_out_data  (o_bit_data)
   );

   // ==========================================================
   // Checksum unit
   logic        use_tx;
   logic        crc_on;
   logic        nbs_trig;
   logic        nbs_bit;
   logic        wbs_trig;
   logic        wbs_bit;
   logic        nbs_go;
   logic        wbs_go;
   logic [20:0] crc15_r;
   logic [20:0] crc17_r;
   logic [20:0] crc21_r;

   assign crc_on = i_crc_en || i_crc_spec_en;
   assign use_tx = i_is_tx && i_arb_done && !i_crc_spec_en;

   always_comb begin
      if (use_tx) begin
         nbs_trig = i_tx_nbs_trig;
         nbs_bit  = i_tx_nbs_bit;
         wbs_trig = i_tx_wbs_trig;
         wbs_bit  = i_tx_wbs_bit;
      end else begin
         nbs_trig = o_pc_rx_trig;
         nbs_bit  = rx_bit_r;
         wbs_trig = i_process_trig;
         wbs_bit  = raw_bit_r;
      end
   end

   // Regular steps on any bit, speculative on dominant only
   assign nbs_go = nbs_trig &&
                   (i_crc_en || (i_crc_spec_en && nbs_bit == DSC_DOMINANT));
   assign wbs_go = wbs_trig &&
                   (i_crc_en || (i_crc_spec_en && wbs_bit == DSC_DOMINANT));

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         crc15_r <= DSC_START15;
      end else if (!crc_on) begin
         crc15_r <= DSC_START15;
      end else if (nbs_go) begin
         crc15_r <= crc_step(crc15_r, nbs_bit, DSC_POLY15, DSC_CRC15_W);
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         crc17_r <= DSC_START17;
         crc21_r <= DSC_START21;
      end else if (!crc_on) begin
         crc17_r <= DSC_START17;
         crc21_r <= DSC_START21;
      end else if (wbs_go) begin
         crc17_r <= crc_step(crc17_r, wbs_bit, DSC_POLY17, DSC_CRC17_W);
         crc21_r <= crc_step(crc21_r, wbs_bit, DSC_POLY21, DSC_CRC21_W);
      end
   end

   assign o_crc15 = crc15_r[14:0];
   assign o_crc17 = crc17_r[16:0];
   assign o_crc21 = crc21_r[20:0];

   // ==========================================================
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   regular_drop_a: assert property (
      i_destuff_trig && mode == DSC_REGULAR && run_cnt_r == DSC_REG_LEN
      |=> o_destuffed)
      else $error("regular stuff bit not dropped");

   fixed_drop_a: assert property (
      i_destuff_trig && mode == DSC_FIXED && run_cnt_r == DSC_FIX_LEN
      |=> o_destuffed)
      else $error("fixed stuff bit not dropped");

   first_fixed_a: assert property (
      i_destuff_trig && mode == DSC_FIXED && !fixed_prev_r |=> o_destuffed)
      else $error("first fixed bit not dropped");

   output_reg_a: assert property (
      i_destuff_trig |=> o_rx_bit == $past(i_rx_bit))
      else $error("destuffer output not one clock late");

   off_quiet_a: assert property (
      i_destuff_trig && !i_destuff_en |=> !o_destuffed && !o_stuff_err)
      else $error("disabled destuffer dropped a bit");

   err_pulse_a: assert property (
      o_stuff_err |=> !o_stuff_err)
      else $error("stuff error longer than one cycle");

   err_cause_a: assert property (
      o_stuff_err |-> o_destuffed && $past(i_rx_bit) == $past(prev_r))
      else $error("stuff error without equal dropped bit");

   run_reset_a: assert property (
      i_destuff_trig && mode == DSC_REGULAR && !discard && i_rx_bit != prev_r
      |=> run_cnt_r == DSC_RUN_START)
      else $error("run counter not reset on polarity change");

   count_up_a: assert property (
      i_destuff_trig && mode == DSC_REGULAR && discard
      |=> o_stuff_cnt == $past(o_stuff_cnt) + DSC_STUFF_ONE)
      else $error("stuff count not advanced");

   gate_trig_a: assert property (
      i_destuff_trig && discard ##1 i_process_trig[*1] |-> !o_pc_rx_trig)
      else $error("receive trigger not gated on stuff bit");

   crc_load_a: assert property (
      !crc_on |=> crc15_r == DSC_START15 && crc17_r == DSC_START17)
      else $error("checksum not loaded with start value");

   spec_hold_a: assert property (
      !i_crc_en && i_crc_spec_en && wbs_bit == DSC_RECESSIVE
      |=> $stable(crc21_r))
      else $error("speculative step on recessive bit");
endmodule

`default_nettype wire

// file: core/dsc_pkg.sv
// Shared constants for the receive destuffer and frame checksum block
package dsc_pkg;
   // ==========================================================
   // Destuff rule lengths and counters
   localparam int unsigned  DSC_CNT_W        = 3;
   localparam logic [2:0]   DSC_REG_LEN      = 3'h5;
   localparam logic [2:0]   DSC_FIX_LEN      = 3'h4;
   localparam logic [2:0]   DSC_RUN_START    = 3'h1;
   localparam logic [2:0]   DSC_RUN_ZERO     = 3'h0;
   localparam logic [2:0]   DSC_STUFF_ONE    = 3'h1;
   localparam logic         DSC_RECESSIVE    = 1'h1;
   localparam logic         DSC_DOMINANT     = 1'h0;

   // ==========================================================
   // Checksum widths, polynomials, start values
   localparam int unsigned  DSC_CRC_MAX_W    = 21;
   localparam int unsigned  DSC_CRC15_W      = 15;
   localparam int unsigned  DSC_CRC17_W      = 17;
   localparam int unsigned  DSC_CRC21_W      = 21;
   localparam logic [20:0]  DSC_POLY15       = 21'h004599;
   localparam logic [20:0]  DSC_POLY17       = 21'h01685b;
   localparam logic [20:0]  DSC_POLY21       = 21'h102899;
   localparam logic [20:0]  DSC_START15      = 21'h000000;
   localparam logic [20:0]  DSC_START17      = 21'h010000;
   localparam logic [20:0]  DSC_START21      = 21'h100000;

   // ==========================================================
   // Destuffer state
   typedef enum logic [1:0] {
      DSC_OFF     = 2'b00,
      DSC_REGULAR = 2'b01,
      DSC_FIXED   = 2'b10
   } dsc_mode_t;
endpackage

// file: verif/dsc_pc_model.sv
// Protocol controller model that consumes received bits from the FIFO
`timescale 1ns/1ns
`default_nettype none
module dsc_pc_model (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_valid,
   input  wire logic       i_data,
   input  wire logic       i_stall,
   output logic            o_ready,
   output logic [7:0]      o_count,
   output logic [7:0]      o_last
);
   // ==========================================================
   // Consumer: stalls on request, otherwise takes every bit
   assign o_ready = !i_stall;

   // Only delivered bits are shifted, so stuff bits never reach it
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_count <= 8'h00;
         o_last  <= 8'h00;
      end else if (i_valid && o_ready) begin
         o_count <= o_count + 8'h01;
         o_last  <= {o_last[6:0], i_data};
      end
   end
endmodule
`default_nettype wire

// file: verif/dsc_destuff_crc_tb.sv
// Self-checking bench for the receive destuffer and checksum block
`timescale 1ns/1ns
`default_nettype none
module dsc_destuff_crc_tb;
   import dsc_pkg::*;
   localparam int unsigned DEPTH   = 4;
   localparam logic [10:0] FIX_PAT = 11'h2e5;
   localparam logic [5:0]  FIL_PAT = 6'h2d;
   logic        clk = 1'b0, rst = 1'b1, trg = 1'b0, rxb = 1'b1, den = 1'b0;
   logic        fix = 1'b0, sof = 1'b0, prc = 1'b0, cen = 1'b0, spc = 1'b0;
   logic        istx = 1'b0, arb = 1'b0, nt = 1'b0, nb = 1'b0, wt = 1'b0;
   logic        wb = 1'b0, stall = 1'b0;
   logic        orx, odst, oerr, opc, bv, br, bd, rrdy, prev, fx;
   logic [2:0]  ocnt, scnt;
   logic [14:0] c15;
   logic [16:0] c17;
   logic [20:0] c21, e15, e17, e21;
   logic [7:0]  pcnt, plast, exp_n, exp_sh;
   int          run, fcnt, occ, num_errors, n_tests;

   always #2 clk = ~clk;

   dsc_destuff_crc #(.FIFO_DEPTH(DEPTH)) dut_u (
      .i_clk(clk), .i_rst(rst), .i_destuff_trig(trg), .i_rx_bit(rxb),
      .i_destuff_en(den), .i_fixed_mode(fix), .i_sof_window(sof),
      .i_process_trig(prc), .o_rx_bit(orx), .o_destuffed(odst),
      .o_stuff_err(oerr), .o_stuff_cnt(ocnt), .o_pc_rx_trig(opc),
      .o_bit_valid(bv), .i_bit_ready(br), .o_bit_data(bd), .o_rx_ready(rrdy),
      .i_crc_en(cen), .i_crc_spec_en(spc), .i_is_tx(istx), .i_arb_done(arb),
      .i_tx_nbs_trig(nt), .i_tx_nbs_bit(nb), .i_tx_wbs_trig(wt),
      .i_tx_wbs_bit(wb), .o_crc15(c15), .o_crc17(c17), .o_crc21(c21));

   dsc_pc_model pc_u (
      .i_clk(clk), .i_rst(rst), .i_valid(bv), .i_data(bd), .i_stall(stall),
      .o_ready(br), .o_count(pcnt), .o_last(plast));

   // ==========================================================
   // Comparison, reference checksum and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [20:0] lfsr(input logic [20:0] c, input logic b,
                                        input logic [20:0] p, input int unsigned w);
      logic [20:0] m;
      logic        fb;
      m  = (21'h1 << w) - 21'h1;
      fb = b ^ c[w-1];
      return ((c << 1) ^ (fb ? p : 21'h0)) & m;
   endfunction

   task automatic chk_crc();
      chk(32'(c15), 32'(e15));
      chk(32'(c17), 32'(e17));
      chk(32'(c21), 32'(e21));
   endtask

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // One received bit through destuff and process stages
   task automatic send(input logic b);
      logic d;
      logic e;
      d = 1'b0;
      e = 1'b0;
      if (!stall) occ = 0;
      if (!den) begin
         run = 1;
         fx  = 1'b0;
         if (sof && !b) scnt = 3'h0;
      end else if (fix) begin
         if (!fx) fcnt = 4;
         fx = 1'b1;
         if (fcnt == 4) begin
            d    = 1'b1;
            e    = (b == prev);
            fcnt = 0;
         end else fcnt++;
      end else if (run == 5) begin
         d    = 1'b1;
         e    = (b == prev);
         run  = 1;
         scnt = scnt + 3'h1;
      end else run = (b == prev) ? run + 1 : 1;
      prev = b;
      // A full FIFO drops the bit, so only DEPTH pushes count while stalled
      if (!d && occ < DEPTH) begin
         occ++;
         exp_n++;
         exp_sh = {exp_sh[6:0], b};
      end
      @(negedge clk);
      trg = 1'b1;
      rxb = b;
      @(negedge clk);
      trg = 1'b0;
      prc = 1'b1;
      #1;
      chk(32'(orx), 32'(b));
      chk(32'(odst), 32'(d));
      chk(32'(oerr), 32'(e));
      chk(32'(opc), 32'(!d));
      if ((cen || (spc && !b)) && !(istx && arb && !spc)) begin
         e17 = lfsr(e17, b, DSC_POLY17, DSC_CRC17_W);
         e21 = lfsr(e21, b, DSC_POLY21, DSC_CRC21_W);
         if (!d) e15 = lfsr(e15, b, DSC_POLY15, DSC_CRC15_W);
      end
      @(negedge clk);
      prc = 1'b0;
      chk(32'(oerr), 32'h0);
      chk_crc();
   endtask

   task automatic tx(input logic w, input logic b);
      @(negedge clk);
      nt = !w;
      wt = w;
      nb = b;
      wb = b;
      if (arb && w) begin
         e17 = lfsr(e17, b, DSC_POLY17, DSC_CRC17_W);
         e21 = lfsr(e21, b, DSC_POLY21, DSC_CRC21_W);
      end else if (arb) e15 = lfsr(e15, b, DSC_POLY15, DSC_CRC15_W);
      @(negedge clk);
      nt = 1'b0;
      wt = 1'b0;
   endtask

   task automatic crc_off();
      cen = 1'b0;
      spc = 1'b0;
      e15 = DSC_START15;
      e17 = DSC_START17;
      e21 = DSC_START21;
      repeat (2) @(negedge clk);
      chk_crc();
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      {run, occ, num_errors, n_tests} = '0;
      fcnt = 0;
      {prev, fx, scnt, exp_n, exp_sh} = {1'b1, 1'b0, 3'h0, 8'h00, 8'h00};
      {e15, e17, e21} = {DSC_START15, DSC_START17, DSC_START21};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk(32'(ocnt), 32'h0);
      chk(32'(rrdy), 32'h1);
      chk(32'(bv), 32'h0);
      chk_crc();
      // Regular frame, speculative start, wrap of the stuff count
      sof = 1'b1;
      spc = 1'b1;
      send(1'b1);
      send(1'b0);
      {sof, spc, cen, den} = 4'hb;
      for (int k = 0; k < 10; k++) begin
         repeat (4) send(k[0]);
         send(!k[0]);
      end
      chk(32'(ocnt), 32'(scnt));
      repeat (5) send(1'b0);
      den = 1'b0;
      crc_off();
      // Fixed mode after a regular start
      sof = 1'b1;
      send(1'b0);
      sof = 1'b0;
      den = 1'b1;
      repeat (4) send(1'b0);
      send(1'b1);
      chk(32'(ocnt), 32'h1);
      fix = 1'b1;
      for (int i = 10; i >= 0; i--) send(FIX_PAT[i]);
      den = 1'b0;
      fix = 1'b0;
      // Disable mid-run, as on an error frame request
      sof = 1'b1;
      send(1'b0);
      sof = 1'b0;
      den = 1'b1;
      repeat (4) send(1'b0);
      den = 1'b0;
      repeat (2) send(1'b0);
      // Fill the FIFO while the controller stalls, then drain it
      // Let the last pushed bit be taken before the stall begins
      @(negedge clk);
      stall = 1'b1;
      occ = 0;
      for (int i = 5; i >= 0; i--) send(FIL_PAT[i]);
      chk(32'(rrdy), 32'h0);
      stall = 1'b0;
      repeat (8) @(negedge clk);
      chk(32'(bv), 32'h0);
      chk(32'(pcnt), 32'(exp_n));
      chk(32'(plast), 32'(exp_sh));
      // Transmitter source before and after arbitration
      cen = 1'b1;
      istx = 1'b1;
      tx(1'b0, 1'b1);
      tx(1'b1, 1'b1);
      chk_crc();
      arb = 1'b1;
      tx(1'b0, 1'b1);
      tx(1'b0, 1'b0);
      tx(1'b1, 1'b1);
      tx(1'b1, 1'b0);
      chk_crc();
      crc_off();
      conclude();
   end

   initial begin
      #20000;
      num_errors++;
      conclude();
   end
endmodule
`default_nettype wire
